// ==== dv/phypcs_mac_model.sv ====
/*
 * MAC model for the MII transmit side.
 * Assumes the block makes txClk and samples on its rising edge.
 */
`timescale 1ns/1ps
module phypcs_mac_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // MII transmit side.
  input wire logic txClk,
  output logic txEn,
  output logic txEr,
  output logic [3:0] txd
);
  logic last_reg;
  // Remembers the transmit clock so its falling edge can be found.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= txClk;
    end
  end
  // Quiet levels before the first frame.
  initial begin
    txEn = 1'b0;
    txEr = 1'b0;
    txd = 4'h0;
  end
  // Sends a frame, one nibble per transmit clock, flagged bad at errAt.
  task automatic send(input logic [3:0] q[$], input int errAt);
    for (int i = 0; i <= q.size(); i++) begin
      do @(posedge clk); while (!(last_reg && !txClk));
      txEn <= i < q.size();
      txEr <= i == errAt;
      txd <= i < q.size() ? q[i] : ~txd;
    end
  endtask : send
endmodule : phypcs_mac_model

// ==== dv/phypcs_mii_pcs_sva.sv ====
/*
 * Port checker of the MII coding sublayer.
 * Assumes it is bound to the top module and shadows the control word.
 */
`timescale 1ns/1ps
module phypcs_mii_pcs_sva (
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] avsAddress,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic avsWaitRequest,
  // MII.
  input wire logic txClk,
  input wire logic rxClk,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [3:0] rxd,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic col,
  // Line.
  input wire logic [4:0] line_transmit_output_pair,
  input wire logic lineTxEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] ctrl_reg;
  logic [3:0] half_reg;
  logic [4:0] quiet_reg;
  wire [4:0] code = line_transmit_output_pair;
  wire wr = avsWrite && !avsWaitRequest && avsAddress == 2'h0;
  wire fast = ctrl_reg[0];
  // Copper test loopback; fiber loopback also hangs on signal detect.
  wire tloop = ctrl_reg[3] && ctrl_reg[1] && !ctrl_reg[2]
               && !(fast && ctrl_reg[5]);
  // Unscrambled fiber mode, the only one whose codes can be read directly.
  wire plain = fast && ctrl_reg[5] && !ctrl_reg[2] && !ctrl_reg[3];
  //////////////////////////////////////////////////////////////////////////
  // Shadow of the control word, clock half period and idle time counters.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= phypcs_pkg::CTRL_RESET;
      half_reg <= 4'h0;
      quiet_reg <= 5'h00;
    end else begin
      ctrl_reg <= wr ? avsWriteData[5:0] : ctrl_reg;
      half_reg <= $changed(txClk) ? 4'h0 : half_reg + 4'h1;
      quiet_reg <= (txEn || wr) ? 5'h00 : quiet_reg + {4'h0, ~&quiet_reg};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_CLK_PAIR: assert property (txClk == rxClk)
    else $error("transmit and receive clocks differ");
  AST_HALF_MAX: assert property (half_reg <= 4'h9)
    else $error("interface clock half period too long");
  AST_LINE_OFF: assert property (
    !fast || tloop |-> !lineTxEnable)
    else $error("line driver enabled");
  AST_IDLE: assert property (
    plain && quiet_reg == 5'h1F |-> code == 5'h1F)
    else $error("no idle code while transmit is off");
  AST_SSD: assert property (
    plain && $rose(txEn) |-> ##[1:12] code == 5'h18 ##[1:2] code == 5'h11)
    else $error("start delimiter missing");
  AST_ESD: assert property (
    plain && $fell(txEn) |-> ##[1:14] code == 5'h0D
      ##[1:2] code == 5'h07 ##[1:2] code == 5'h1F)
    else $error("end delimiter missing");
  AST_HALT: assert property (
    plain && txEn && txEr |-> ##[1:12] code == 5'h04)
    else $error("error code group missing");
  AST_BAD_NIB: assert property (fast && rxEr |-> rxd == 4'hE)
    else $error("wrong nibble with receive error");
  AST_PRE100: assert property (
    fast && $rose(rxDv) |-> rxd == 4'h5)
    else $error("receive valid without preamble");
  AST_SFD10: assert property (
    !fast && !ctrl_reg[3] && (ctrl_reg[4] || ctrl_reg[1]) && $rose(rxDv)
      |-> rxd == 4'hD)
    else $error("receive valid not at frame delimiter");
  AST_NO_COL: assert property (
    ctrl_reg[1] && $past(ctrl_reg[1], 3) |-> !col)
    else $error("collision in full duplex");
  AST_RX_STEP: assert property (
    $changed({rxd, rxDv, rxEr}) |-> !rxClk || !$past(rxClk))
    else $error("receive outputs moved off the receive clock");
endmodule : phypcs_mii_pcs_sva

// ==== dv/tb.sv ====
/*
 * Self-checking bench of the MII coding sublayer.
 * Assumes the MAC model of its own file and the port checker.
 */
`timescale 1ns/1ps
module tb;
  logic clk, arst_n, avsRead, avsWrite, avsWaitRequest, sd;
  logic [1:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd, lfsr;
  logic txClk, rxClk, rxDv, rxEr, crs, col, txEn, txEr, lineTxEnable;
  logic lineRxActive, line10RxActive, lastTx, lastRx, colSeen, crsSeen;
  logic [3:0] txd, rxd, line10RxNibble;
  logic [4:0] lineCode, lineRxCode;
  logic [4:0] txq[$], rxq[$], c[$], e[$];
  logic [3:0] fr[$];
  int err_count, n_tests, cyc, n;
  // Data code groups of nibbles 0 to F.
  localparam logic [4:0] ENC[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
    5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
    5'h1D};
  phypcs_mii_pcs dut (.clk(clk), .arst_n(arst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .txClk(txClk), .txEn(txEn), .txEr(txEr), .txd(txd), .rxClk(rxClk),
    .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .crs(crs), .col(col),
    .line_transmit_output_pair(lineCode), .lineTxEnable(lineTxEnable),
    .lineRxCode(lineRxCode), .lineRxActive(lineRxActive),
    .line10RxNibble(line10RxNibble), .line10RxActive(line10RxActive),
    .fiber_signal_detect_input(sd));
  phypcs_mac_model mac (.clk(clk), .arst_n(arst_n), .txClk(txClk),
    .txEn(txEn), .txEr(txEr), .txd(txd));
  //////////////////////////////////////////////////////////////////////////
  // Clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Collects line codes and receive nibbles, and cuts a hang short.
  always @(posedge clk) begin
    lastTx <= txClk;
    lastRx <= rxClk;
    if (col)
      colSeen <= 1'b1;
    if (crs)
      crsSeen <= 1'b1;
    cyc <= cyc + 1;
    if (txClk && !lastTx && lineTxEnable && lineCode != 5'h1F)
      txq.push_back(lineCode);
    if (rxClk && !lastRx && rxDv)
      rxq.push_back({rxEr, rxd});
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string w, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  task automatic cmpq(input string w, input logic [4:0] x[$],
    input logic [4:0] g[$]);
    chk(w, 8'(x.size()), 8'(g.size()));
    foreach (x[i]) chk(w, {3'h0, x[i]}, i < g.size() ? {3'h0, g[i]} : 8'hFF);
  endtask : cmpq
  // One bus transfer held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [1:0] a, input logic [5:0] d);
    avsAddress <= a;
    avsWriteData <= {26'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic setc(input logic [5:0] v);
    bus(1'b1, 2'h0, v);
    repeat (60) @(posedge clk);
  endtask : setc
  // Preamble nibbles, the delimiter nibble, then random data.
  task automatic mk(input int nd);
    fr = '{4'h5, 4'h5, 4'h5, 4'h5, 4'hD};
    repeat (nd) begin
      lfsr = nxt(lfsr);
      fr.push_back(lfsr[3:0]);
    end
  endtask : mk
  // Drives line symbols, one per receive clock, then goes idle.
  task automatic lineSend(input logic [4:0] q[$], input logic f);
    for (int i = 0; i <= q.size(); i++) begin
      do @(posedge clk); while (!(lastRx && !rxClk));
      lineRxCode <= i < q.size() && f ? q[i] : 5'h1F;
      lineRxActive <= i < q.size() && f;
      line10RxNibble <= i < q.size() && !f ? q[i][3:0] : 4'hA;
      line10RxActive <= i < q.size() && !f;
    end
    repeat (60) @(posedge clk);
  endtask : lineSend
  task automatic txTest(input int errAt, input logic dup);
    setc(6'h21 | {4'h0, dup, 1'b0});
    mk(6);
    txq = {};
    crsSeen = 1'b0;
    mac.send(fr, errAt);
    repeat (60) @(posedge clk);
    e = '{5'h18, 5'h11};
    for (int i = 2; i < fr.size(); i++)
      e.push_back(i == errAt ? 5'h04 : ENC[fr[i]]);
    e.push_back(5'h0D);
    e.push_back(5'h07);
    cmpq("line codes", e, txq);
    chk("tx carrier", {7'h0, !dup}, {7'h0, crsSeen});
    $display("transmit test done");
  endtask : txTest
  task automatic rxTest(input logic dup);
    setc(6'h21 | {4'h0, dup, 1'b0});
    mk(6);
    c = '{5'h18, 5'h11};
    e = {};
    foreach (fr[i]) e.push_back(i == 8 ? 5'h1E : {1'b0, fr[i]});
    for (int i = 2; i < fr.size(); i++) c.push_back(i == 8 ? 5'h00 : ENC[fr[i]]);
    c.push_back(5'h0D);
    c.push_back(5'h07);
    rxq = {};
    colSeen = 1'b0;
    fork
      mac.send(fr, 99);
      lineSend(c, 1'b1);
    join
    cmpq("rx nibbles", e, rxq);
    chk("collision", {7'h0, !dup}, {7'h0, colSeen});
    $display("receive test done");
  endtask : rxTest
  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    {avsRead, avsWrite, avsAddress, avsWriteData, sd, cyc} = '0;
    {lineRxActive, line10RxActive, line10RxNibble, err_count, n_tests} = '0;
    lineRxCode = 5'h1F;
    lfsr = 32'h0B549589;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 2'h0, 6'h00);
    chk("ctrl reset", 8'h05, rd[7:0]);
    bus(1'b1, 2'h3, 6'h3F);
    bus(1'b0, 2'h2, 6'h00);
    chk("unmapped", 8'h00, rd[7:0]);
    bus(1'b0, 2'h0, 6'h00);
    chk("ctrl kept", 8'h05, rd[7:0]);
    $display("register test done");
    // Interface clock period in system clocks: 40 ns and 400 ns over 20 ns.
    for (int k = 0; k < 2; k++) begin
      setc(k ? 6'h00 : 6'h21);
      do @(posedge clk); while (!(txClk && !lastTx));
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!(txClk && !lastTx));
      chk("clock period", k ? 8'h14 : 8'h02, 8'(n));
    end
    $display("clock test done");
    sd <= 1'b1;
    txTest(99, 1'b0);
    txTest(9, 1'b1);
    rxTest(1'b0);
    rxTest(1'b1);
    // Echo at 10 Mbps: on in half duplex, off when disabled or full duplex.
    for (int k = 0; k < 3; k++) begin
      setc(k == 0 ? 6'h00 : k == 1 ? 6'h10 : 6'h02);
      rxq = {};
      mk(2);
      mac.send(fr, 99);
      repeat (60) @(posedge clk);
      chk("echo", {7'h0, k == 0}, {7'h0, rxq.size() != 0});
    end
    $display("echo test done");
    mk(3);
    c = {};
    e = {};
    foreach (fr[i]) c.push_back({1'b0, fr[i]});
    foreach (fr[i]) if (i > 3) e.push_back(c[i]);
    rxq = {};
    lineSend(c, 1'b0);
    cmpq("rx 10 nibbles", e, rxq);
    $display("10 Mbps receive test done");
    // Test loopback entry over copper and fiber settings.
    for (int k = 0; k < 4; k++) begin
      sd <= k == 2;
      setc(k == 0 ? 6'h0B : k == 1 ? 6'h0F : 6'h29);
      chk("line enable", {7'h0, k[0]}, {7'h0, lineTxEnable});
    end
    setc(6'h0B);
    // Status word: only the test loopback bit while the MAC is quiet.
    bus(1'b0, 2'h1, 6'h00);
    chk("status", 8'h20, rd[7:0]);
    mk(4);
    e = {};
    foreach (fr[i]) e.push_back({1'b0, fr[i]});
    rxq = {};
    mac.send(fr, 99);
    repeat (60) @(posedge clk);
    cmpq("loop nibbles", e, rxq);
    $display("loopback test done");
    finish_test();
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
endmodule : tb
bind phypcs_mii_pcs phypcs_mii_pcs_sva sva (.clk(clk), .arst_n(arst_n),
  .avsAddress(avsAddress), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsWaitRequest(avsWaitRequest), .txClk(txClk), .rxClk(rxClk),
  .txEn(txEn), .txEr(txEr), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .col(col),
  .line_transmit_output_pair(line_transmit_output_pair),
  .lineTxEnable(lineTxEnable));

// ==== include/phypcs_pkg.sv ====
/*
 * Shared constants of the MII-side coding sublayer: 4B/5B code groups,
 * clock divider counts, the nibble substituted on a line error and the
 * register map of the configuration and status words.
 * Assumes a 50 MHz system clock and an Avalon-MM master of 32-bit data.
 */
package phypcs_pkg;

  // Register word addresses on the bus.
  localparam logic [1:0] CTRL_ADDR = 2'h0;
  localparam logic [1:0] STAT_ADDR = 2'h1;

  // Control word field positions.
  localparam int CTRL_SPEED100 = 0;
  localparam int CTRL_FULLDUP = 1;
  localparam int CTRL_ANEG = 2;
  localparam int CTRL_LOOPBACK = 3;
  localparam int CTRL_ECHO_DIS = 4;
  localparam int CTRL_FIBER = 5;
  localparam int CTRL_WIDTH = 6;
  localparam logic [5:0] CTRL_RESET = 6'h05;

  // Clock rates and divider half periods.
  localparam int SYS_CLK_HZ = 50000000;
  localparam int MII_FAST_HZ = 25000000;
  localparam int MII_SLOW_HZ = 2500000;
  localparam int HALF_FAST = SYS_CLK_HZ / (2 * MII_FAST_HZ);
  localparam int HALF_SLOW = SYS_CLK_HZ / (2 * MII_SLOW_HZ);

  // Code groups.
  localparam logic [4:0] CODE_J = 5'h18;
  localparam logic [4:0] CODE_K = 5'h11;
  localparam logic [4:0] CODE_T = 5'h0D;
  localparam logic [4:0] CODE_R = 5'h07;
  localparam logic [4:0] CODE_IDLE = 5'h1F;
  localparam logic [4:0] CODE_ERR = 5'h04;

  // Nibbles seen on the receive side.
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_SFD_LOW = 4'hD;
  localparam logic [3:0] NIB_BAD = 4'hE;

  // Transmit encoder states.
  typedef enum logic [2:0] {
    TX_IDLE, TX_SEND_K, TX_DATA, TX_SEND_T, TX_SEND_R
  } phypcs_tx_t;

endpackage : phypcs_pkg

// ==== rtl/phypcs_code_rom.sv ====
/*
 * Registered 4B/5B code tables: data nibble to code group, and code group
 * back to nibble with a flag for groups that carry no data.
 * Assumes one shared clock and an asynchronous active low reset.
 */
`timescale 1ns/1ps
module phypcs_code_rom (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Encode side.
  input wire logic [3:0] encNibble,
  output logic [4:0] encCode,
  // Decode side.
  input wire logic [4:0] decCode,
  output logic [3:0] decNibble,
  output logic decBad
);

  ////////////////////////////////////////////////////////////////////////
  // Constant tables.
  localparam logic [79:0] ENC_TABLE = {
    5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};

  logic [3:0] decHit;
  logic decValid;

  // Reverse lookup by a generate search over the sixteen data groups.
  logic [15:0] match;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gSearch
      assign match[g] = (ENC_TABLE[g*5 +: 5] == decCode);
    end
  endgenerate

  // Priority encoding of the one-hot match vector; the highest set bit wins.
  always_comb begin
    decHit = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (match[i]) begin
        decHit = 4'(i);
      end
    end
  end
  assign decValid = |match;

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      encCode <= 5'h1F;
      decNibble <= 4'h0;
      decBad <= 1'b0;
    end else begin
      encCode <= ENC_TABLE[encNibble*5 +: 5];
      decNibble <= decHit;
      decBad <= !decValid;
    end
  end

endmodule : phypcs_code_rom

// ==== rtl/phypcs_mii_pcs.sv ====
/*
 * PHY side of the MII with the 100 Mbps coding sublayer: makes the MII
 * clocks, encodes transmit nibbles into framed code groups, decodes
 * receive code groups, and drives carrier sense, collision and loopback.
 * Assumes line symbols arrive one per receive clock from a serialiser
 * outside, already aligned, and that the MAC keeps to the MII timing.
 */
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module phypcs_mii_pcs (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Avalon-MM slave.
  input wire logic [1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // MII transmit side.
  output logic txClk,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [3:0] txd,
  // MII receive side.
  output logic rxClk,
  output logic [3:0] rxd,
  output logic rxDv,
  output logic rxEr,
  output logic crs,
  output logic col,
  // Line side, 100 Mbps symbols.
  output logic [4:0] line_transmit_output_pair,
  output logic lineTxEnable,
  input wire logic [4:0] lineRxCode,
  input wire logic lineRxActive,
  // Line side, 10 Mbps nibbles already recovered.
  input wire logic [3:0] line10RxNibble,
  input wire logic line10RxActive,
  // Fiber signal detect.
  input wire logic fiber_signal_detect_input
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration register and bus slave.
  logic [5:0] ctrl_reg;
  logic readPending_reg;
  wire selCtrl = (avsAddress == phypcs_pkg::CTRL_ADDR);
  wire selStat = (avsAddress == phypcs_pkg::STAT_ADDR);
  wire speed100 = ctrl_reg[phypcs_pkg::CTRL_SPEED100];
  wire fullDup = ctrl_reg[phypcs_pkg::CTRL_FULLDUP];
  wire anegOn = ctrl_reg[phypcs_pkg::CTRL_ANEG];
  wire loopBit = ctrl_reg[phypcs_pkg::CTRL_LOOPBACK];
  wire echoDis = ctrl_reg[phypcs_pkg::CTRL_ECHO_DIS];
  wire fiberSel = ctrl_reg[phypcs_pkg::CTRL_FIBER];

  // Writes finish at once; reads take one wait cycle for registered data.
  assign avsWaitRequest = avsRead && !readPending_reg;

  // Control register write and read pending flag.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= phypcs_pkg::CTRL_RESET;
      readPending_reg <= 1'b0;
    end else begin
      if (avsWrite && selCtrl) begin
        ctrl_reg <= avsWriteData[5:0];
      end
      readPending_reg <= avsRead && !readPending_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode.
  // Fiber is only legal with negotiation off.
  wire fiberMode = fiberSel && !anegOn && speed100;
  wire sdSync;
  // Copper test loopback needs full duplex and no negotiation.
  wire testLoopCu = loopBit && fullDup && !anegOn && !fiberMode;
  // Fiber test loopback needs signal detect high.
  wire testLoopFx = loopBit && fiberMode && sdSync;
  wire testLoop = testLoopCu || testLoopFx;
  // Echo only at 10 Mbps half duplex with echo enabled.
  wire echoOn = !speed100 && !fullDup && !echoDis && !testLoop;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for line and fiber inputs.
  logic [1:0] sdMeta_reg;
  logic [1:0] rxActMeta_reg;
  logic [1:0] rx10ActMeta_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdMeta_reg <= 2'h0;
      rxActMeta_reg <= 2'h0;
      rx10ActMeta_reg <= 2'h0;
    end else begin
      sdMeta_reg <= {sdMeta_reg[0], fiber_signal_detect_input};
      rxActMeta_reg <= {rxActMeta_reg[0], lineRxActive};
      rx10ActMeta_reg <= {rx10ActMeta_reg[0], line10RxActive};
    end
  end
  assign sdSync = sdMeta_reg[1];
  wire rxActSync = rxActMeta_reg[1];
  wire rx10ActSync = rx10ActMeta_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // MII clock divider, shared by both MII clocks.
  logic [3:0] div_reg;
  logic miiClk_reg;
  // Divider count follows the link speed.
  wire [3:0] halfCount = speed100 ? 4'(phypcs_pkg::HALF_FAST - 1)
                                  : 4'(phypcs_pkg::HALF_SLOW - 1);
  wire divWrap = (div_reg >= halfCount);
  // Rising edge of the MII clock happens on the next clock edge.
  wire miiRise = divWrap && !miiClk_reg;
  // Falling edge: outputs change here, half a period before sampling.
  wire miiFall = divWrap && miiClk_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 4'h0;
      miiClk_reg <= 1'b0;
    end else begin
      div_reg <= divWrap ? 4'h0 : div_reg + 4'h1;
      miiClk_reg <= divWrap ? !miiClk_reg : miiClk_reg;
    end
  end
  assign txClk = miiClk_reg;
  assign rxClk = miiClk_reg;

  ////////////////////////////////////////////////////////////////////////
  // Transmit capture on the MII rising edge.
  logic [3:0] txdCap_reg;
  logic txEnCap_reg;
  logic txErCap_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txdCap_reg <= 4'h0;
      txEnCap_reg <= 1'b0;
      txErCap_reg <= 1'b0;
    end else if (miiRise) begin
      txdCap_reg <= txd;
      txEnCap_reg <= txEn;
      txErCap_reg <= txEr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code tables.  The encoder registers the pin nibble on every clock, one clock
  // before the falling edge, so the code group matches the captured transmit enable.
  logic [4:0] encCode;
  logic [3:0] decNibble;
  logic decBad;
  phypcs_code_rom uRom (
    .clk(clk),
    .arst_n(arst_n),
    .encNibble(txd),
    .encCode(encCode),
    .decCode(lineRxCode),
    .decNibble(decNibble),
    .decBad(decBad)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmit encoder. Transmit enable framing is the MAC's.
  phypcs_pkg::phypcs_tx_t txState_reg, txState_next;
  logic [4:0] txCode_reg, txCode_next;
  logic [10:0] scr_reg;
  logic txActive;

  // Next state and code group, advanced once per MII period.
  always_comb begin
    txState_next = txState_reg;
    txCode_next = txCode_reg;
    case (txState_reg)
      phypcs_pkg::TX_IDLE: begin
        txCode_next = phypcs_pkg::CODE_IDLE;
        if (txEnCap_reg) begin
          txCode_next = phypcs_pkg::CODE_J;
          txState_next = phypcs_pkg::TX_SEND_K;
        end
      end
      phypcs_pkg::TX_SEND_K: begin
        txCode_next = phypcs_pkg::CODE_K;
        txState_next = txEnCap_reg ? phypcs_pkg::TX_DATA
                                   : phypcs_pkg::TX_SEND_R;
        if (!txEnCap_reg) begin
          txCode_next = phypcs_pkg::CODE_T;
        end
      end
      phypcs_pkg::TX_DATA: begin
        if (!txEnCap_reg) begin
          txCode_next = phypcs_pkg::CODE_T;
          txState_next = phypcs_pkg::TX_SEND_R;
        end else if (txErCap_reg) begin
          txCode_next = phypcs_pkg::CODE_ERR;
        end else begin
          txCode_next = encCode;
        end
      end
      phypcs_pkg::TX_SEND_R: begin
        txCode_next = phypcs_pkg::CODE_R;
        txState_next = phypcs_pkg::TX_IDLE;
      end
      default: begin
        txCode_next = phypcs_pkg::CODE_IDLE;
        txState_next = phypcs_pkg::TX_IDLE;
      end
    endcase
  end
  assign txActive = txEnCap_reg;

  // Stream scrambler for copper, stepped with each symbol.
  wire [10:0] scrNext = {scr_reg[9:0], scr_reg[10] ^ scr_reg[8]};
  wire scrOn = speed100 && !fiberMode;
  wire [4:0] lineCode = scrOn ? (txCode_reg ^ scr_reg[4:0]) : txCode_reg;

  // State, code and scrambler registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_reg <= phypcs_pkg::TX_IDLE;
      txCode_reg <= phypcs_pkg::CODE_IDLE;
      scr_reg <= 11'h7FF;
    end else if (miiFall) begin
      txState_reg <= txState_next;
      txCode_reg <= txCode_next;
      scr_reg <= scrNext;
    end
  end

  // Line output, silenced in test loopback.
  logic [4:0] lineOut_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lineOut_reg <= phypcs_pkg::CODE_IDLE;
    end else begin
      lineOut_reg <= lineCode;
    end
  end
  assign line_transmit_output_pair = lineOut_reg;
  assign lineTxEnable = speed100 && !testLoop;

  ////////////////////////////////////////////////////////////////////////
  // Receive path.  The descrambler steps like the transmit scrambler but is not applied to received code groups.
  logic [10:0] dscr_reg;
  logic rxInFrame_reg;
  logic [1:0] rxJk_reg;
  logic [3:0] rxd_reg;
  logic rxDv_reg;
  logic rxEr_reg;
  logic rx10Seen_reg;

  // Receive source select: loopback, echo, 100 Mbps line or 10 Mbps line.
  wire lineActive = speed100 ? rxActSync : rx10ActSync;
  wire rxLoop = testLoop || (echoOn && txActive);
  wire rxActive = rxLoop ? txActive : (lineActive && !testLoop);
  wire jkPhase = (rxJk_reg != 2'h0);
  // 10 Mbps frames start on the first D nibble.
  wire rx10Start = (line10RxNibble == phypcs_pkg::NIB_SFD_LOW);

  // Code group delayed one clock to line up with the registered decode.
  logic [4:0] rxCodeDly_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxCodeDly_reg <= phypcs_pkg::CODE_IDLE;
    end else begin
      rxCodeDly_reg <= lineRxCode;
    end
  end
  // End delimiter groups close the frame and carry no data.
  wire rxEsd = (rxCodeDly_reg == phypcs_pkg::CODE_T)
            || (rxCodeDly_reg == phypcs_pkg::CODE_R);

  // Receive outputs change only on the falling MII edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_reg <= 4'h0;
      rxDv_reg <= 1'b0;
      rxEr_reg <= 1'b0;
      rxInFrame_reg <= 1'b0;
      rxJk_reg <= 2'h0;
      rx10Seen_reg <= 1'b0;
      dscr_reg <= 11'h7FF;
    end else if (miiFall) begin
      dscr_reg <= {dscr_reg[9:0], dscr_reg[10] ^ dscr_reg[8]};
      rxInFrame_reg <= rxActive;
      rxEr_reg <= 1'b0;
      if (!rxActive) begin
        rxDv_reg <= 1'b0;
        rxJk_reg <= 2'h0;
        rx10Seen_reg <= 1'b0;
      end else if (rxLoop) begin
        rxd_reg <= txdCap_reg;
        rxDv_reg <= 1'b1;
        rxEr_reg <= txErCap_reg;
      end else if (speed100) begin
        rxDv_reg <= 1'b1;
        if (!rxInFrame_reg) begin
          rxJk_reg <= 2'h1;
          rxd_reg <= phypcs_pkg::NIB_PREAMBLE;
        end else if (jkPhase) begin
          rxJk_reg <= 2'h0;
          rxd_reg <= phypcs_pkg::NIB_PREAMBLE;
        end else if (rxEsd) begin
          rxDv_reg <= 1'b0;
        end else if (decBad) begin
          rxd_reg <= phypcs_pkg::NIB_BAD;
          rxEr_reg <= 1'b1;
        end else begin
          rxd_reg <= decNibble;
        end
      end else begin
        if (rx10Start || rx10Seen_reg) begin
          rx10Seen_reg <= 1'b1;
          rxDv_reg <= 1'b1;
          rxd_reg <= line10RxNibble;
        end
      end
    end
  end
  assign rxd = rxd_reg;
  assign rxDv = rxDv_reg;
  assign rxEr = rxEr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision, combinational from activity.
  wire lineRx = lineActive && !testLoop;
  assign crs = lineRx || (rxLoop && txActive)
             || (!fullDup && txEnCap_reg);
  assign col = !fullDup && !testLoop && txEnCap_reg && lineRx;

  ////////////////////////////////////////////////////////////////////////
  // Control and status read data, registered.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avsReadData <= 32'h0;
    end else if (avsRead) begin
      if (selCtrl) begin
        avsReadData <= {26'h0, ctrl_reg};
      end else if (selStat) begin
        avsReadData <= {26'h0, testLoop, echoOn, fiberMode, col, crs,
                        txActive};
      end else begin
        avsReadData <= 32'h0;
      end
    end
  end

endmodule : phypcs_mii_pcs
